// File: core/pcs_pkg.sv
// pcs_pkg: constants and carrier types for the program/data address unit.
// assumes one 20 MHz core clock and a synchronous active-low reset.
package pcs_pkg;
	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0] PCS_OFF_PCL   = 8'h00; // pc_low_byte
	localparam logic [7:0] PCS_OFF_LATCH = 8'h04; // pc_high_latch
	localparam logic [7:0] PCS_OFF_FSP   = 8'h08; // file_select_pointer
	localparam logic [7:0] PCS_OFF_BANK  = 8'h0c; // bank bits
	localparam logic [7:0] PCS_OFF_EFF   = 8'h10; // indirect address, ro
	// register select codes
	localparam logic [2:0] PCS_SEL_PCL   = 3'h0;
	localparam logic [2:0] PCS_SEL_LATCH = 3'h1;
	localparam logic [2:0] PCS_SEL_FSP   = 3'h2;
	localparam logic [2:0] PCS_SEL_BANK  = 3'h3;
	localparam logic [2:0] PCS_SEL_EFF   = 3'h4;
	localparam logic [2:0] PCS_SEL_NONE  = 3'h7;
	// ****************************************
	// field positions, reset and interrupt addresses, port and response codes
	// ****************************************
	localparam int          PCS_IRP_BIT   = 7; // indirect_bank_bit
	localparam int          PCS_RP_LO     = 5; // direct_bank_bits lo
	localparam logic [12:0] PCS_PC_RST    = 13'h0000;
	localparam logic [12:0] PCS_IRQ_VEC   = 13'h0004;
	localparam logic [6:0]  PCS_IND_PORT  = 7'h00; // indirect_data_port
	localparam logic [1:0]  PCS_RESP_OKAY = 2'h0;
	localparam logic [1:0]  PCS_RESP_ERR  = 2'h2;
	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic        direct_jump;     // pulse
		logic        subroutine_jump; // pulse
		logic        irq_branch;      // pulse
		logic        ret;             // any return kind, pulse
		logic        step;            // advance by one
		logic [10:0] target;          // literal from opcode
	} pcs_instr_t;
	typedef struct packed {
		logic       valid;
		logic       we;
		logic [6:0] loc;   // 7-bit location from opcode
		logic [7:0] wdata;
	} pcs_file_t;
	typedef struct packed {
		logic       re;
		logic       we;
		logic [8:0] addr;
		logic [7:0] wdata;
	} pcs_mem_t;
endpackage

// File: core/pcs_core.sv
// pcs_core: program counter, return stack, direct/indirect data addressing.
// assumes the decoder issues at most one flow pulse per cycle and that
// data memory returns read data in the cycle after the registered request.
`timescale 1ns/100ps
`default_nettype none
module pcs_core (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// axi4-lite write address/data/response
	input  wire logic [7:0]       s_awaddr,
	input  wire logic             s_awvalid,
	output logic                  s_awready,
	input  wire logic [31:0]      s_wdata,
	input  wire logic [3:0]       s_wstrb,
	input  wire logic             s_wvalid,
	output logic                  s_wready,
	output logic [1:0]            s_bresp,
	output logic                  s_bvalid,
	input  wire logic             s_bready,
	// axi4-lite read
	input  wire logic [7:0]       s_araddr,
	input  wire logic             s_arvalid,
	output logic                  s_arready,
	output logic [31:0]           s_rdata,
	output logic [1:0]            s_rresp,
	output logic                  s_rvalid,
	input  wire logic             s_rready,
	// decoder side
	input  wire pcs_pkg::pcs_instr_t instr,
	input  wire pcs_pkg::pcs_file_t  file_req,
	output logic [7:0]            file_rdata,
	output logic [12:0]           prog_addr,
	// data memory side
	output pcs_pkg::pcs_mem_t     mem_req,
	input  wire logic [7:0]       mem_rdata
);
	import pcs_pkg::*;

	// ****************************************
	// address decode
	// ****************************************
	// shared by read and write channels
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		unique case (a)
			PCS_OFF_PCL:   reg_sel = PCS_SEL_PCL;
			PCS_OFF_LATCH: reg_sel = PCS_SEL_LATCH;
			PCS_OFF_FSP:   reg_sel = PCS_SEL_FSP;
			PCS_OFF_BANK:  reg_sel = PCS_SEL_BANK;
			PCS_OFF_EFF:   reg_sel = PCS_SEL_EFF;
			default:       reg_sel = PCS_SEL_NONE;
		endcase
	endfunction

	logic [12:0] pc_r;        // program counter
	logic [7:0]  latch_r;     // pc_high_latch
	logic [7:0]  fsp_r;       // file_select_pointer
	logic        irp_r;       // indirect_bank_bit
	logic [1:0]  rp_r;        // direct_bank_bits
	logic [12:0] stk_r [8];   // return stack
	logic [2:0]  sp_r;        // next free slot, hidden
	logic        aw_got_r;    // address held
	logic [7:0]  aw_addr_r;
	logic        w_got_r;     // data held
	logic [7:0]  w_data_r;    // only the low byte is stored
	logic        w_strb_r;
	logic        wr_fire;     // both halves present
	logic [2:0]  wr_sel;
	logic        pcl_wr;      // software low-byte write
	logic        push;
	logic        pop;
	logic [12:0] stk_top;     // entry a pop returns
	logic [8:0]  ind_addr;    // bank bit plus pointer
	logic        self_ind_r;  // access through port at port
	logic        self_ind_d_r; // same flag, lined up with read data

	// ****************************************
	// axi4-lite write channel
	// ****************************************
	assign s_awready = !aw_got_r;
	assign s_wready  = !w_got_r;
	assign wr_fire   = aw_got_r && w_got_r && !s_bvalid;
	assign wr_sel    = reg_sel(aw_addr_r);

	// hold each half until both are in; either order works
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_got_r   <= 1'b0;
			w_data_r  <= 8'h00;
			w_strb_r  <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= s_awaddr;
			end else if (wr_fire) begin
				aw_got_r <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_got_r  <= 1'b1;
				w_data_r <= s_wdata[7:0];
				w_strb_r <= s_wstrb[0];
			end else if (wr_fire) begin
				w_got_r <= 1'b0;
			end
		end
	end

	// response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_bvalid <= 1'b0;
			s_bresp  <= PCS_RESP_OKAY;
		end else if (wr_fire) begin
			s_bvalid <= 1'b1;
			// unmapped or read-only offsets answer slverr
			s_bresp  <= (wr_sel == PCS_SEL_NONE || wr_sel == PCS_SEL_EFF)
				? PCS_RESP_ERR : PCS_RESP_OKAY;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// software-written registers
	// ****************************************
	// byte lane 0 carries every register; other lanes are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_r <= 8'h00;
			fsp_r   <= 8'h00;
			irp_r   <= 1'b0;
			rp_r    <= 2'h0;
		end else if (wr_fire && w_strb_r) begin
			unique case (wr_sel)
				PCS_SEL_LATCH: latch_r <= w_data_r;
				PCS_SEL_FSP:   fsp_r <= w_data_r;
				PCS_SEL_BANK: begin
					irp_r <= w_data_r[PCS_IRP_BIT];
					rp_r  <= w_data_r[PCS_RP_LO +: 2];
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// axi4-lite read channel
	// ****************************************
	assign s_arready = !s_rvalid;

	// upper pc bits and the stack pointer have no read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= PCS_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp  <= PCS_RESP_OKAY;
			unique case (reg_sel(s_araddr))
				PCS_SEL_PCL:   s_rdata <= {24'h0, pc_r[7:0]};
				PCS_SEL_LATCH: s_rdata <= {24'h0, latch_r};
				PCS_SEL_FSP:   s_rdata <= {24'h0, fsp_r};
				PCS_SEL_BANK:  s_rdata <= {24'h0, irp_r, rp_r, 5'h00};
				PCS_SEL_EFF:   s_rdata <= {23'h0, ind_addr};
				default: begin
					s_rdata <= 32'h0000_0000;
					s_rresp <= PCS_RESP_ERR;
				end
			endcase
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// program counter
	// ****************************************
	assign push    = instr.irq_branch || instr.subroutine_jump;
	assign pop     = !push && instr.ret;
	assign pcl_wr  = wr_fire && w_strb_r && wr_sel == PCS_SEL_PCL;
	assign stk_top = stk_r[sp_r - 3'd1];
	assign prog_addr = pc_r;

	// jumps, calls, interrupts and returns beat a same-cycle software write; a step loses to it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_r <= PCS_PC_RST;
		end else if (instr.irq_branch) begin
			pc_r <= PCS_IRQ_VEC;
		end else if (instr.subroutine_jump || instr.direct_jump) begin
			pc_r <= {latch_r[4:3], instr.target};
		end else if (pop) begin
			pc_r <= stk_top;
		end else if (pcl_wr) begin
			// upper five bits come from the latch, the low byte from the write data
			pc_r <= {latch_r[4:0], w_data_r};
		end else if (instr.step) begin
			pc_r <= pc_r + 13'd1;
		end
	end

	// ****************************************
	// return stack
	// ****************************************
	// pointer wraps freely; no flag is kept for over/underflow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_r <= 3'h0;
		end else if (push) begin
			sp_r <= sp_r + 3'd1;
		end else if (pop) begin
			sp_r <= sp_r - 3'd1;
		end
	end

	// storage has no reset; latch is not touched here
	always_ff @(posedge aclk) begin
		if (push) begin
			stk_r[sp_r] <= pc_r;
		end
	end

	// ****************************************
	// data addressing
	// ****************************************
	assign ind_addr = {irp_r, fsp_r};

	// registered request toward data memory
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_req    <= '0;
			self_ind_r <= 1'b0;
		end else if (file_req.valid && file_req.loc == PCS_IND_PORT) begin
			// no storage at the port; pointer picks the target
			mem_req.addr  <= ind_addr;
			mem_req.wdata <= file_req.wdata;
			// port pointing at itself in any bank stores nothing
			mem_req.we <= file_req.we
				&& fsp_r[6:0] != PCS_IND_PORT;
			mem_req.re <= !file_req.we;
			self_ind_r <= fsp_r[6:0] == PCS_IND_PORT;
		end else if (file_req.valid) begin
			mem_req.addr  <= {rp_r, file_req.loc};
			mem_req.wdata <= file_req.wdata;
			mem_req.we    <= file_req.we;
			mem_req.re    <= !file_req.we;
			self_ind_r    <= 1'b0;
		end else begin
			mem_req.we <= 1'b0;
			mem_req.re <= 1'b0;
			self_ind_r <= 1'b0;
		end
	end

	// data memory answers one cycle after the registered request, so
	// the flag is delayed once more to cover the returned byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			self_ind_d_r <= 1'b0;
		end else begin
			self_ind_d_r <= self_ind_r;
		end
	end

	// self-indirect read is forced to zero
	assign file_rdata = self_ind_d_r ? 8'h00 : mem_rdata;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_pcl_only;
		pcl_wr && !push && !instr.ret && !instr.direct_jump;
	endsequence
	sequence s_self_ind;
		file_req.valid && file_req.loc == PCS_IND_PORT
			&& fsp_r[6:0] == PCS_IND_PORT;
	endsequence
	sequence s_step_only;
		instr.step && !push && !instr.ret && !instr.direct_jump
			&& !pcl_wr;
	endsequence

	// program counter loads
	a_reset_pc_zero: assert property (
		$rose(aresetn) |-> pc_r == 13'h0000)
		else $error("pc not zero after reset");
	a_pcl_load: assert property (
		s_pcl_only |=> pc_r == {$past(latch_r[4:0]), $past(w_data_r)})
		else $error("low-byte write loaded wrong pc");
	a_jump_load: assert property (
		instr.direct_jump && !push
		|=> pc_r == {$past(latch_r[4:3]), $past(instr.target)})
		else $error("jump loaded wrong pc");
	// return stack
	a_push_store: assert property (
		push |=> stk_r[$past(sp_r)] == $past(pc_r)
			&& sp_r == $past(sp_r) + 3'd1)
		else $error("push did not store pc");
	a_pop_return: assert property (
		pop |=> pc_r == $past(stk_top) && sp_r == $past(sp_r) - 3'd1)
		else $error("pop did not restore pc");
	a_latch_kept: assert property (
		(push || pop) && !wr_fire |=> $stable(latch_r))
		else $error("latch changed by stack action");
	a_call_return: assert property (
		instr.subroutine_jump ##1 (!push && pop)
		|=> pc_r == $past(pc_r, 2))
		else $error("call then return lost address");
	// data addressing
	a_self_zero: assert property (
		(s_self_ind and !file_req.we) |=> ##1 file_rdata == 8'h00)
		else $error("self-indirect read not zero");
	a_self_nowrite: assert property (
		s_self_ind |=> !mem_req.we)
		else $error("self-indirect write reached memory");
	a_ind_address: assert property (
		file_req.valid && file_req.loc == PCS_IND_PORT
		|=> mem_req.addr == {$past(irp_r), $past(fsp_r)})
		else $error("indirect address wrong");
	a_dir_address: assert property (
		file_req.valid && file_req.loc != PCS_IND_PORT
		|=> mem_req.addr == {$past(rp_r), $past(file_req.loc)})
		else $error("direct address wrong");

	// flow cases not covered above
	a_irq_vector: assert property (
		instr.irq_branch |=> pc_r == PCS_IRQ_VEC)
		else $error("interrupt did not load vector");
	a_step_advance: assert property (
		s_step_only |=> pc_r == $past(pc_r) + 13'd1)
		else $error("step did not advance pc");
	// with no flow event and no software write the pc must hold
	a_pc_idle: assert property (
		!push && !instr.ret && !instr.direct_jump && !pcl_wr
			&& !instr.step
		|=> pc_r == $past(pc_r))
		else $error("pc moved with no cause");
	// register writes never reach the hidden pointer
	a_stack_idle: assert property (
		!push && !pop |=> sp_r == $past(sp_r))
		else $error("stack pointer moved with no cause");
endmodule // pcs_core
`default_nettype wire

// File: testbench/pcs_mem_model.sv
// pcs_mem_model: behavioural data memory standing behind the address unit.
// assumes one core clock and a registered read answer one cycle after re.
`timescale 1ns/100ps
`default_nettype none
module pcs_mem_model (
	// clock
	input  wire logic              aclk,
	// request in, read data out
	input  wire pcs_pkg::pcs_mem_t mem_req,
	output logic [7:0]             mem_rdata
);
	import pcs_pkg::*;
	logic [7:0] store [512]; // four banks of 128 bytes
	// preset non-zero at address 0, so a suppressed read cannot pass as zero by luck
	initial begin
		for (int i = 0; i < 512; i++) begin
			store[i] = i[7:0] ^ 8'h5a;
		end
		mem_rdata = 8'h00;
	end
	// answer a read next cycle; between answers the line keeps moving
	always @(posedge aclk) begin
		if (mem_req.we) begin
			store[mem_req.addr] <= mem_req.wdata;
		end
		if (mem_req.re) begin
			mem_rdata <= store[mem_req.addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // pcs_mem_model
`default_nettype wire

// File: testbench/pcs_core_test.sv
// pcs_core_test: register, flow and data-address checks for pcs_core.
// assumes pcs_mem_model answers data reads; the bench acts as decoder.
`timescale 1ns/100ps
`default_nettype none
module pcs_core_test;
	import pcs_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        aclk, aresetn;
	logic [7:0]  s_awaddr, s_araddr, file_rdata, mem_rdata;
	logic [31:0] s_wdata, s_rdata;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready;
	pcs_instr_t  instr;
	pcs_file_t   file_req;
	pcs_mem_t    mem_req;
	logic [12:0] prog_addr, pc_exp;
	logic [12:0] stk [8]; // expected return stack
	logic [2:0]  sp;      // wraps like the real pointer
	int          bad_count, comparisons;
	pcs_core pcs_core_i (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
		.s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .instr(instr), .file_req(file_req),
		.file_rdata(file_rdata), .prog_addr(prog_addr), .mem_req(mem_req),
		.mem_rdata(mem_rdata));
	pcs_mem_model pcs_mem_model_i (.aclk(aclk), .mem_req(mem_req),
		.mem_rdata(mem_rdata));
	// 20 MHz core clock
	always #25 aclk = ~aclk;
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// a handshake that never completes ends the run
	task automatic hang();
		bad_count++;
		$display("[ERR] %0t handshake did not complete", $time);
		conclude();
	endtask
	// write: both channels offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic aw_hs, w_hs, b_hs;
		logic [1:0] resp;
		@(posedge aclk);
		s_awaddr  <= a;
		s_awvalid <= 1'b1;
		s_wdata   <= {24'h000000, d};
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge aclk);
			aw_hs = s_awvalid && s_awready;
			w_hs  = s_wvalid && s_wready;
			b_hs  = s_bvalid;
			resp  = s_bresp;
			@(posedge aclk);
			if (aw_hs) s_awvalid <= 1'b0;
			if (w_hs) s_wvalid <= 1'b0;
			if (b_hs) begin
				s_bready <= 1'b0;
				check(resp, er);
				return;
			end
		end
		hang();
	endtask
	// read: rready held until the answer is seen at an edge
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ar_hs, r_hs;
		logic [31:0] d;
		logic [1:0]  resp;
		@(posedge aclk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge aclk);
			ar_hs = s_arvalid && s_arready;
			r_hs  = s_rvalid;
			d     = s_rdata;
			resp  = s_rresp;
			@(posedge aclk);
			if (ar_hs) s_arvalid <= 1'b0;
			if (r_hs) begin
				s_rready <= 1'b0;
				check(d, ed);
				check(resp, er);
				return;
			end
		end
		hang();
	endtask
	function automatic pcs_instr_t mk(input logic j, c, q, r,
		input logic [10:0] t);
		mk = '{j, c, q, r, 1'b0, t};
	endfunction
	// one-cycle flow pulse, new pc visible after the taking edge
	task automatic flow(input pcs_instr_t v, input logic [12:0] exp);
		@(posedge aclk);
		instr <= v;
		@(posedge aclk);
		instr <= '0;
		#1;
		check(prog_addr, exp);
		pc_exp = exp;
	endtask
	// data access: registered request, then the answer a cycle later
	task automatic file_op(input logic we, input logic [6:0] loc,
		input logic [7:0] wd, input logic [8:0] ea, input logic ew,
		input logic [7:0] ed);
		@(posedge aclk);
		file_req <= '{1'b1, we, loc, wd};
		@(posedge aclk);
		file_req <= '0;
		#1;
		check({mem_req.we, mem_req.addr}, {ew, ea});
		if (!we) begin
			@(posedge aclk);
			#1;
			check(file_rdata, ed);
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{aclk, aresetn, s_awaddr, s_araddr, s_wdata} = '0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{bad_count, comparisons, sp} = '0;
		s_wstrb  = 4'h1;
		instr    = '0;
		file_req = '0;
		repeat (10) @(posedge aclk);
		#1;
		check(prog_addr, 13'h0000);
		@(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(PCS_OFF_PCL, 32'h0, PCS_RESP_OKAY);
		axi_wr(PCS_OFF_LATCH, 8'h1f, PCS_RESP_OKAY);
		axi_wr(PCS_OFF_PCL, 8'ha5, PCS_RESP_OKAY);
		check(prog_addr, 13'h1fa5);
		axi_rd(PCS_OFF_PCL, 32'ha5, PCS_RESP_OKAY);
		axi_wr(PCS_OFF_LATCH, 8'h1b, PCS_RESP_OKAY);
		check(prog_addr, 13'h1fa5);
		flow(mk(1'b1, 1'b0, 1'b0, 1'b0, 11'h123), 13'h1923);
		flow('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 11'h000}, 13'h1924);
		// nine calls and an interrupt overrun the eight slots
		for (int k = 0; k < 9; k++) begin
			stk[sp] = pc_exp;
			sp = sp + 3'h1;
			flow(mk(1'b0, 1'b1, 1'b0, 1'b0, 11'h100 + 11'(k)), 13'h1900 + 13'(k));
		end
		stk[sp] = pc_exp;
		sp = sp + 3'h1;
		flow(mk(1'b0, 1'b0, 1'b1, 1'b0, 11'h000), PCS_IRQ_VEC);
		for (int k = 0; k < 10; k++) begin
			sp = sp - 3'h1;
			flow(mk(1'b0, 1'b0, 1'b0, 1'b1, 11'h000), stk[sp]);
		end
		// call and return on consecutive cycles
		@(posedge aclk);
		instr <= mk(1'b0, 1'b1, 1'b0, 1'b0, 11'h055);
		@(posedge aclk);
		instr <= mk(1'b0, 1'b0, 1'b0, 1'b1, 11'h000);
		#1;
		check(prog_addr, 13'h1855);
		@(posedge aclk);
		instr <= '0;
		#1;
		check(prog_addr, pc_exp);
		axi_rd(PCS_OFF_LATCH, 32'h1b, PCS_RESP_OKAY);
		axi_rd(8'h14, 32'h0, PCS_RESP_ERR);
		axi_wr(PCS_OFF_EFF, 8'hff, PCS_RESP_ERR);
		// indirect through the pointer, both halves of the data space
		axi_wr(PCS_OFF_FSP, 8'h35, PCS_RESP_OKAY);
		for (int b = 0; b < 2; b++) begin
			axi_wr(PCS_OFF_BANK, {b[0], 7'h00}, PCS_RESP_OKAY);
			axi_rd(PCS_OFF_EFF, {23'h0, b[0], 8'h35}, PCS_RESP_OKAY);
			file_op(1'b1, PCS_IND_PORT, 8'hc3 + 8'(b), {b[0], 8'h35}, 1'b1, 8'h00);
			file_op(1'b0, PCS_IND_PORT, 8'h00, {b[0], 8'h35}, 1'b0, 8'hc3 + 8'(b));
		end
		axi_wr(PCS_OFF_BANK, 8'h60, PCS_RESP_OKAY);
		file_op(1'b0, 7'h12, 8'h00, 9'h192, 1'b0, 8'hc8);
		// pointer aimed at the port itself
		axi_wr(PCS_OFF_FSP, 8'h00, PCS_RESP_OKAY);
		axi_wr(PCS_OFF_BANK, 8'h00, PCS_RESP_OKAY);
		file_op(1'b0, PCS_IND_PORT, 8'h00, 9'h000, 1'b0, 8'h00);
		file_op(1'b1, PCS_IND_PORT, 8'h77, 9'h000, 1'b0, 8'h00);
		// second reset in mid-run clears the pc and the latch again
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
		check(prog_addr, 13'h0000);
		@(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(PCS_OFF_LATCH, 32'h0, PCS_RESP_OKAY);
		conclude();
	end
endmodule // pcs_core_test
`default_nettype wire
